/* rtl/prot_ctrl.sv */
`timescale 1ns/10ps
`include "prot_map.svh"
module prot_ctrl import prot_pkg::*; #(
  parameter logic [15:0] STEP = `STEP_CYCLES
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [7:0] VCELL_I,
  input wire logic [4:0] RATIO_I,
  input wire logic REF_OK_I,
  output logic [3:0] CELL_CH_O,
  output logic [2:0] TEMP_CH_O,
  output logic CELL_BIST_O,
  output logic TEMP_BIST_O,
  output logic [15:0] BAL_STOP_O,
  output logic [15:0] BAL_PAUSE_O
);
  typedef struct packed {
    logic [31:0] rdata;
    logic slverr;
    cell_cfg_t cell_sw;
    temp_cfg_t temp_sw;
    cell_cfg_t cell_cfg;
    temp_cfg_t temp_cfg;
    logic cell_go;
    logic temp_go;
    logic [15:0] ov_flt;
    logic [15:0] uv_flt;
    logic [7:0] ot_flt;
    logic [7:0] ut_flt;
    logic [15:0] bal_stop;
    logic [15:0] bal_pause;
  } st_t;
  st_t q, d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic cell_run, cell_valid, cell_bist;
  logic temp_run, temp_valid, temp_bist;
  logic [3:0] cell_ch;
  logic [2:0] temp_ch;
  logic wr, rd;
  logic [2:0] pin_sel;
  logic [15:0] cell_active;
  logic [15:0] ov_set, uv_set, done_set, ov_clr, uv_clr;
  logic [7:0] ot_set, ut_set, bot_set, ot_clr, ut_clr;
  logic [15:0] stop_clr, pause_clr;
  sample_t smp;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  prot_sequencer #(.CH(16), .CW(4), .STEP(STEP)) u_cell_seq (
    .clk_i(CLK_I),
    .rst_ni(rst_n),
    .start_i(q.cell_go),
    .mode_i(q.cell_cfg.mode), // R23
    .lock_i(q.cell_cfg.lock),
    .run_o(cell_run), // R5
    .ch_o(cell_ch),
    .valid_o(cell_valid),
    .bist_o(cell_bist)
  );
  prot_sequencer #(.CH(8), .CW(3), .STEP(STEP)) u_temp_seq (
    .clk_i(CLK_I),
    .rst_ni(rst_n),
    .start_i(q.temp_go),
    .mode_i(q.temp_cfg.mode), // R14
    .lock_i(q.temp_cfg.lock),
    .run_o(temp_run), // R20
    .ch_o(temp_ch),
    .valid_o(temp_valid),
    .bist_o(temp_bist)
  );

  assign wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign smp = '{vcell: VCELL_I, ratio: RATIO_I, ref_ok: REF_OK_I};
  assign pin_sel = q.temp_cfg.pin_conf[3*temp_ch +: 3];

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_cell
      assign cell_active[g] = (4'(g) <= q.cell_cfg.top_ch); // R25
      assign ov_set[g] = cell_valid && cell_ch == 4'(g) && cell_active[g]
        && smp.vcell > q.cell_cfg.ov_thr; // R24 R3 R4
      assign uv_set[g] = cell_valid && cell_ch == 4'(g) && cell_active[g] && !q.cell_cfg.uv_mask[g]
        && smp.vcell < q.cell_cfg.uv_thr; // R24 R4
      assign done_set[g] = cell_valid && cell_ch == 4'(g) && cell_active[g]
        && q.cell_cfg.mode == MODE_ROBIN && smp.vcell < q.cell_cfg.done_thr; // R26 R8
    end
    for (g = 0; g < 8; g++) begin : g_temp
      // Without the reference every input reports both faults
      assign ot_set[g] = temp_valid && temp_ch == 3'(g)
        && (!smp.ref_ok || pin_sel == `PIN_ADC_PROTECT && smp.ratio < q.temp_cfg.ot_thr); // R10 R11 R9 R13
      assign ut_set[g] = temp_valid && temp_ch == 3'(g)
        && (!smp.ref_ok || pin_sel == `PIN_ADC_PROTECT && smp.ratio > {2'h0, q.temp_cfg.ut_thr}); // R12 R13
      assign bot_set[g] = temp_valid && temp_ch == 3'(g) && pin_sel == `PIN_ADC_PROTECT
        && q.temp_cfg.mode == MODE_ROBIN && smp.ref_ok
        && smp.ratio < q.temp_cfg.bal_ot_thr[4:0]; // R16 R22
    end
  endgenerate

  assign ov_clr = (wr && PADDR_I == `A_OV_FAULT_A) ? {8'h00, PWDATA_I[7:0]} :
    (wr && PADDR_I == `A_OV_FAULT_B) ? {PWDATA_I[7:0], 8'h00} : 16'h0000;
  assign uv_clr = (wr && PADDR_I == `A_UV_FAULT_A) ? {8'h00, PWDATA_I[7:0]} :
    (wr && PADDR_I == `A_UV_FAULT_B) ? {PWDATA_I[7:0], 8'h00} : 16'h0000;
  assign ot_clr = (wr && PADDR_I == `A_OT_FAULT) ? PWDATA_I[7:0] : 8'h00;
  assign ut_clr = (wr && PADDR_I == `A_UT_FAULT) ? PWDATA_I[7:0] : 8'h00;
  assign stop_clr = (wr && PADDR_I == `A_BAL_STOP) ? PWDATA_I[15:0] : 16'h0000;
  assign pause_clr = (wr && PADDR_I == `A_BAL_PAUSE) ? PWDATA_I[15:0] : 16'h0000;

  always_comb begin
    d = q;
    d.cell_go = 1'b0;
    d.temp_go = 1'b0;
    // Write-one-to-clear, a new hit in the same cycle wins
    d.ov_flt = (q.ov_flt & ~ov_clr) | ov_set; // R7 R28
    d.uv_flt = (q.uv_flt & ~uv_clr) | uv_set; // R7 R28
    d.ot_flt = (q.ot_flt & ~ot_clr) | ot_set; // R21 R28
    d.ut_flt = (q.ut_flt & ~ut_clr) | ut_set; // R21 R28
    d.bal_stop = (q.bal_stop & ~stop_clr) | done_set; // R8
    d.bal_pause = (q.bal_pause & ~pause_clr) | {8'h00, bot_set}; // R22
    d.slverr = 1'b0;
    if (wr) begin
      unique case (PADDR_I)
        `A_CELL_CTRL: begin
          d.cell_sw.mode = mode_t'(PWDATA_I[`F_MODE_LO +: 2]);
          d.cell_sw.lock = PWDATA_I[`F_LOCK_LO +: 4];
          if (PWDATA_I[`F_START]) begin
            d.cell_cfg = d.cell_sw; // R1 R2
            d.cell_go = 1'b1;
          end
        end
        `A_OV_THR: d.cell_sw.ov_thr = PWDATA_I[7:0];
        `A_UV_THR: d.cell_sw.uv_thr = PWDATA_I[7:0];
        `A_BAL_DONE_THR: d.cell_sw.done_thr = PWDATA_I[7:0];
        `A_ACTIVE_CH: d.cell_sw.top_ch = PWDATA_I[3:0];
        `A_UV_MASK_LO: d.cell_sw.uv_mask[7:0] = PWDATA_I[7:0];
        `A_UV_MASK_HI: d.cell_sw.uv_mask[15:8] = PWDATA_I[7:0];
        `A_TEMP_CTRL: begin
          d.temp_sw.mode = mode_t'(PWDATA_I[`F_MODE_LO +: 2]);
          d.temp_sw.lock = PWDATA_I[`F_LOCK_LO +: 3];
          if (PWDATA_I[`F_START]) begin
            d.temp_cfg = d.temp_sw; // R19
            d.temp_go = 1'b1;
          end
        end
        `A_TEMP_THR: begin
          d.temp_sw.ot_thr = PWDATA_I[4:0];
          d.temp_sw.ut_thr = PWDATA_I[7:5];
        end
        `A_BAL_OT_THR: d.temp_sw.bal_ot_thr = PWDATA_I[7:0];
        `A_PIN_CONF: d.temp_sw.pin_conf = PWDATA_I[23:0];
        `A_STATUS, `A_OV_FAULT_A, `A_OV_FAULT_B, `A_UV_FAULT_A, `A_UV_FAULT_B,
        `A_OT_FAULT, `A_UT_FAULT, `A_BAL_STOP, `A_BAL_PAUSE: d.slverr = 1'b0;
        default: d.slverr = 1'b1;
      endcase
    end
    if (rd) begin
      d.rdata = 32'h00000000;
      unique case (PADDR_I)
        `A_CELL_CTRL: d.rdata = {25'h0, q.cell_sw.lock, q.cell_sw.mode, 1'b0};
        `A_OV_THR: d.rdata = {24'h0, q.cell_sw.ov_thr};
        `A_UV_THR: d.rdata = {24'h0, q.cell_sw.uv_thr};
        `A_BAL_DONE_THR: d.rdata = {24'h0, q.cell_sw.done_thr};
        `A_ACTIVE_CH: d.rdata = {28'h0, q.cell_sw.top_ch};
        `A_UV_MASK_LO: d.rdata = {24'h0, q.cell_sw.uv_mask[7:0]};
        `A_UV_MASK_HI: d.rdata = {24'h0, q.cell_sw.uv_mask[15:8]};
        `A_TEMP_CTRL: d.rdata = {26'h0, q.temp_sw.lock, q.temp_sw.mode, 1'b0};
        `A_TEMP_THR: d.rdata = {24'h0, q.temp_sw.ut_thr, q.temp_sw.ot_thr};
        `A_BAL_OT_THR: d.rdata = {24'h0, q.temp_sw.bal_ot_thr};
        `A_PIN_CONF: d.rdata = {8'h0, q.temp_sw.pin_conf};
        `A_STATUS: d.rdata = {28'h0, temp_bist, cell_bist, temp_run, cell_run}; // R6 R21
        `A_OV_FAULT_A: d.rdata = {24'h0, q.ov_flt[7:0]};
        `A_OV_FAULT_B: d.rdata = {24'h0, q.ov_flt[15:8]};
        `A_UV_FAULT_A: d.rdata = {24'h0, q.uv_flt[7:0]};
        `A_UV_FAULT_B: d.rdata = {24'h0, q.uv_flt[15:8]};
        `A_OT_FAULT: d.rdata = {24'h0, q.ot_flt};
        `A_UT_FAULT: d.rdata = {24'h0, q.ut_flt};
        `A_BAL_STOP: d.rdata = {16'h0, q.bal_stop};
        `A_BAL_PAUSE: d.rdata = {16'h0, q.bal_pause};
        default: d.slverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      {q.rdata, q.slverr, q.cell_sw, q.temp_sw, q.cell_cfg, q.temp_cfg, q.cell_go, q.temp_go,
        q.ov_flt, q.uv_flt, q.ot_flt, q.ut_flt, q.bal_stop, q.bal_pause} <= '0;
    end else begin
      {q.rdata, q.slverr, q.cell_sw, q.temp_sw, q.cell_cfg, q.temp_cfg, q.cell_go, q.temp_go,
        q.ov_flt, q.uv_flt, q.ot_flt, q.ut_flt, q.bal_stop, q.bal_pause} <=
      {d.rdata, d.slverr, d.cell_sw, d.temp_sw, d.cell_cfg, d.temp_cfg, d.cell_go, d.temp_go,
        d.ov_flt, d.uv_flt, d.ot_flt, d.ut_flt, d.bal_stop, d.bal_pause};
    end
  end

  assign PRDATA_O = q.rdata;
  assign PREADY_O = PSEL_I && PENABLE_I;
  assign PSLVERR_O = PSEL_I && PENABLE_I && (q.slverr || d.slverr && wr);
  assign CELL_CH_O = cell_ch;
  assign TEMP_CH_O = temp_ch;
  assign CELL_BIST_O = cell_bist;
  assign TEMP_BIST_O = temp_bist;
  assign BAL_STOP_O = q.bal_stop;
  assign BAL_PAUSE_O = q.bal_pause;
endmodule

/* rtl/prot_map.svh */
`ifndef PROT_MAP_SVH
`define PROT_MAP_SVH
// Summary of operation
// R1 - Cell start latches thresholds, mode, masks
// R2 - New settings need another start
// R3 - One OV and UV threshold for all
// R4 - Drop inactive and UV-masked channel results
// R5 - Cell protectors keep running in sleep
// R6 - Cell running status bit reads one
// R7 - OV and UV hits in two registers each
// R8 - Balance-done hit only stops that channel
// R9 - OT 5-bit, UT 3-bit thresholds shared
// R10 - Only ADC-and-protect pins are active
// R11 - OT fault when ratio below threshold
// R12 - UT fault when ratio above threshold
// R13 - No reference: all temperature faults set
// R14 - Temp mode: stop, round-robin, self-test, single
// R15 - Temp round-robin fixed step, inactive ignored
// R16 - Round-robin OT checks balance OT too
// R17 - Temp self-test blocks temperature detections
// R18 - Single mode stays on locked input
// R19 - Temp start latches settings and pin configs
// R20 - Temp protectors keep running in sleep
// R21 - Temp running bit, OT UT fault registers
// R22 - Balance OT hit only pauses that channel
// R23 - Cell mode decode, 4-bit channel lock
// R24 - OV above threshold, UV below threshold
// R25 - Highest active channel, lower ones active
// R26 - Cell round-robin checks UV and balance-done
// R27 - Start with stop mode halts and clears
// R28 - Faults stick until software clears
`define A_CELL_CTRL 12'h000
`define A_OV_THR 12'h004
`define A_UV_THR 12'h008
`define A_BAL_DONE_THR 12'h00c
`define A_ACTIVE_CH 12'h010
`define A_UV_MASK_LO 12'h014
`define A_UV_MASK_HI 12'h018
`define A_TEMP_CTRL 12'h01c
`define A_TEMP_THR 12'h020
`define A_BAL_OT_THR 12'h024
`define A_PIN_CONF 12'h028
`define A_STATUS 12'h02c
`define A_OV_FAULT_A 12'h030
`define A_OV_FAULT_B 12'h034
`define A_UV_FAULT_A 12'h038
`define A_UV_FAULT_B 12'h03c
`define A_OT_FAULT 12'h040
`define A_UT_FAULT 12'h044
`define A_BAL_STOP 12'h048
`define A_BAL_PAUSE 12'h04c
`define F_START 0
`define F_MODE_LO 1
`define F_LOCK_LO 3
`define PIN_ADC_PROTECT 3'h2
`define STEP_CYCLES 16'h0040
`endif

/* rtl/prot_pkg.sv */
package prot_pkg;
  typedef enum logic [1:0] {
    MODE_STOP,
    MODE_ROBIN,
    MODE_BIST,
    MODE_SINGLE
  } mode_t;
  typedef struct packed {
    logic [7:0] ov_thr;
    logic [7:0] uv_thr;
    logic [7:0] done_thr;
    logic [3:0] top_ch;
    logic [15:0] uv_mask;
    mode_t mode;
    logic [3:0] lock;
  } cell_cfg_t;
  typedef struct packed {
    logic [4:0] ot_thr;
    logic [2:0] ut_thr;
    logic [7:0] bal_ot_thr;
    logic [23:0] pin_conf;
    mode_t mode;
    logic [2:0] lock;
  } temp_cfg_t;
  typedef struct packed {
    logic [7:0] vcell;
    logic [4:0] ratio;
    logic ref_ok;
  } sample_t;
endpackage

/* rtl/prot_sequencer.sv */
`timescale 1ns/10ps
`include "prot_map.svh"
module prot_sequencer import prot_pkg::*; #(
  parameter int CH = 16,
  parameter int CW = 4,
  parameter logic [15:0] STEP = `STEP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_ni,
  input wire logic start_i,
  input wire mode_t mode_i,
  input wire logic [CW-1:0] lock_i,
  output logic run_o,
  output logic [CW-1:0] ch_o,
  output logic valid_o,
  output logic bist_o
);
  typedef struct packed {
    logic run;
    mode_t mode;
    logic [CW-1:0] ch;
    logic [15:0] cnt;
    logic valid;
  } seq_t;
  seq_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.valid = 1'b0;
    if (start_i) begin
      s_d.mode = mode_i;
      s_d.run = (mode_i != MODE_STOP); // R27
      s_d.cnt = 16'h0000;
      s_d.ch = (mode_i == MODE_SINGLE) ? lock_i : '0;
    end else if (s_q.run) begin
      // Fixed step per channel regardless of active count
      if (s_q.cnt == STEP - 16'h0001) begin // R15
        s_d.cnt = 16'h0000;
        s_d.valid = (s_q.mode != MODE_BIST); // R17
        if (s_q.mode != MODE_SINGLE) begin // R18
          s_d.ch = (s_q.ch == CW'(CH - 1)) ? '0 : s_q.ch + 1'b1;
        end
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign run_o = s_q.run;
  assign ch_o = s_q.ch;
  assign valid_o = s_q.valid;
  assign bist_o = s_q.run && (s_q.mode == MODE_BIST);
endmodule

/* sim/prot_ctrl_chk.sv */
`timescale 1ns/10ps
`include "prot_map.svh"
module prot_ctrl_chk import prot_pkg::*; #(
  parameter logic [15:0] STEP = `STEP_CYCLES
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic [3:0] CELL_CH_O,
  input wire logic [2:0] TEMP_CH_O,
  input wire logic CELL_BIST_O,
  input wire logic TEMP_BIST_O,
  input wire logic [15:0] BAL_STOP_O,
  input wire logic [15:0] BAL_PAUSE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic acc;
  logic [1:0] cm_q, tm_q;
  logic [3:0] cl_q;
  logic [2:0] tl_q, cs_q, ts_q;
  assign acc = PSEL_I && PENABLE_I && PWRITE_I;
  // Settings seen at the last start write, and cycles since it
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      {cm_q, tm_q, cl_q, tl_q, cs_q, ts_q} <= '0;
    end else begin
      if (acc && PADDR_I == `A_CELL_CTRL && PWDATA_I[0]) begin
        {cl_q, cm_q} <= PWDATA_I[6:1];
        cs_q <= 3'h0;
      end else if (cs_q != 3'h7) begin
        cs_q <= cs_q + 3'h1;
      end
      if (acc && PADDR_I == `A_TEMP_CTRL && PWDATA_I[0]) begin
        {tl_q, tm_q} <= PWDATA_I[5:1];
        ts_q <= 3'h0;
      end else if (ts_q != 3'h7) begin
        ts_q <= ts_q + 3'h1;
      end
    end
  end
  AST_READY: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
    else $error("ready missing in access phase");
  AST_IDLE: assert property (!PSEL_I |-> !PREADY_O && !PSLVERR_O)
    else $error("ready or error while idle");
  AST_UNMAPPED: assert property (PSEL_I && PENABLE_I && PADDR_I > 12'h04c |-> PSLVERR_O)
    else $error("unmapped access not refused");
  AST_STOP_STICKY: assert property (|($past(BAL_STOP_O) & ~BAL_STOP_O) |-> $past(acc && PADDR_I == `A_BAL_STOP))
    else $error("balance stop bit fell by itself");
  AST_PAUSE_STICKY: assert property (|($past(BAL_PAUSE_O) & ~BAL_PAUSE_O) |-> $past(acc && PADDR_I == `A_BAL_PAUSE))
    else $error("balance pause bit fell by itself");
  AST_CELL_LOCK: assert property (cm_q == MODE_SINGLE && cs_q >= 3'h3 |-> CELL_CH_O == cl_q)
    else $error("cell channel left its lock");
  AST_TEMP_LOCK: assert property (tm_q == MODE_SINGLE && ts_q >= 3'h3 |-> TEMP_CH_O == tl_q)
    else $error("temp channel left its lock");
  AST_CELL_STOP: assert property (cm_q == MODE_STOP && cs_q >= 3'h3 |-> !CELL_BIST_O)
    else $error("cell self-test while stopped");
  AST_TEMP_STOP: assert property (tm_q == MODE_STOP && ts_q >= 3'h3 |-> !TEMP_BIST_O)
    else $error("temp self-test while stopped");
  AST_TEMP_BIST: assert property (tm_q == MODE_BIST && ts_q >= 3'h3 |-> TEMP_BIST_O)
    else $error("temp self-test not running");
endmodule
bind prot_ctrl prot_ctrl_chk #(.STEP(STEP)) chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .CELL_CH_O(CELL_CH_O), .TEMP_CH_O(TEMP_CH_O), .CELL_BIST_O(CELL_BIST_O),
  .TEMP_BIST_O(TEMP_BIST_O), .BAL_STOP_O(BAL_STOP_O), .BAL_PAUSE_O(BAL_PAUSE_O));

/* sim/prot_analog.sv */
`timescale 1ns/10ps
module prot_analog (
  input wire logic [3:0] cell_ch_i,
  input wire logic [2:0] temp_ch_i,
  input wire logic ref_en_i,
  output logic [7:0] vcell_o,
  output logic [4:0] ratio_o,
  output logic ref_ok_o
);
  logic [7:0] v [16];
  logic [4:0] r [8];
  // Comparators follow whichever channel is selected
  assign vcell_o = v[cell_ch_i];
  assign ratio_o = r[temp_ch_i];
  assign ref_ok_o = ref_en_i;
endmodule

/* sim/tb_prot_ctrl.sv */
`timescale 1ns/10ps
`include "prot_map.svh"
module tb_prot_ctrl import prot_pkg::*; ();
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pw = 0, er, ref_en = 1;
  logic [11:0] pa = 0;
  logic [31:0] pd = 0, rq, prd;
  logic rdy, serr, cbist, tbist;
  logic [7:0] vc, act;
  logic [4:0] ra, ot;
  logic [2:0] ut;
  logic [23:0] pc;
  logic rok;
  logic [3:0] cch;
  logic [2:0] tch;
  logic [15:0] bst, bps, msk, eo, eu, es;
  logic [7:0] eot, eut, ep, bot;
  int n_errors = 0, cmp_count = 0, ovt, uvt, dnt, top;
  always #10 clk = ~clk;
  prot_ctrl #(.STEP(16'h0004)) dut (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pw), .PADDR_I(pa), .PWDATA_I(pd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(serr),
    .VCELL_I(vc), .RATIO_I(ra), .REF_OK_I(rok), .CELL_CH_O(cch), .TEMP_CH_O(tch), .CELL_BIST_O(cbist),
    .TEMP_BIST_O(tbist), .BAL_STOP_O(bst), .BAL_PAUSE_O(bps));
  prot_analog pm (.cell_ch_i(cch), .temp_ch_i(tch), .ref_en_i(ref_en), .vcell_o(vc), .ratio_o(ra), .ref_ok_o(rok));
  task automatic close_out;
    $display("counts: errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chkr(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t register read %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkp(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t pin value %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pw <= w;
    pa <= a;
    pd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    rq = prd;
    er = serr;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chkr(rq, e);
  endtask
  task automatic cgo(input logic [1:0] m, input logic [3:0] lk);
    wr(`A_OV_THR, ovt);
    wr(`A_UV_THR, uvt);
    wr(`A_BAL_DONE_THR, dnt);
    wr(`A_ACTIVE_CH, top);
    wr(`A_UV_MASK_LO, {24'h0, msk[7:0]});
    wr(`A_UV_MASK_HI, {24'h0, msk[15:8]});
    wr(`A_CELL_CTRL, {25'h0, lk, m, 1'b1});
  endtask
  task automatic tgo(input logic [1:0] m, input logic [2:0] lk);
    wr(`A_TEMP_THR, {24'h0, ut, ot});
    wr(`A_BAL_OT_THR, {24'h0, bot});
    wr(`A_PIN_CONF, {8'h0, pc});
    wr(`A_TEMP_CTRL, {26'h0, lk, m, 1'b1});
  endtask
  // Sticky reference model of the cell and temperature detections
  task automatic mexp;
    for (int c = 0; c < 16; c++) begin
      eo[c] = eo[c] | (c <= top && pm.v[c] > ovt);
      eu[c] = eu[c] | (c <= top && !msk[c] && pm.v[c] < uvt);
      es[c] = es[c] | (c <= top && pm.v[c] < dnt);
    end
    for (int c = 0; c < 8; c++) begin
      eot[c] = eot[c] | (act[c] && pm.r[c] < ot);
      eut[c] = eut[c] | (act[c] && pm.r[c] > {2'h0, ut});
      ep[c] = ep[c] | (act[c] && pm.r[c] < bot[4:0]);
    end
  endtask
  task automatic cread;
    rd(`A_OV_FAULT_A, {24'h0, eo[7:0]});
    rd(`A_OV_FAULT_B, {24'h0, eo[15:8]});
    rd(`A_UV_FAULT_A, {24'h0, eu[7:0]});
    rd(`A_UV_FAULT_B, {24'h0, eu[15:8]});
    chkp(bst, es);
  endtask
  task automatic clr(input logic [11:0] a);
    wr(a, 32'hff);
  endtask
  initial begin
    void'($urandom(32'he764));
    for (int c = 0; c < 16; c++) pm.v[c] = 8'($urandom_range(255));
    for (int c = 0; c < 8; c++) pm.r[c] = 5'($urandom_range(31));
    {eo, eu, es, eot, eut, ep} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    for (int a = 'h2c; a <= 'h44; a += 4) rd(12'(a), 32'h0);
    apb(1'b0, 12'h0f0, 32'h0);
    chkr({31'h0, er}, 32'h1);
    $display("test reset and refusal done");
    ovt = 200;
    uvt = 50;
    dnt = 80;
    top = $urandom_range(14, 8);
    msk = 16'h0005;
    pm.v[0] = 8'($urandom_range(255, 100));
    pm.v[2] = 8'h14;
    pm.v[1] = 8'hd2;
    pm.v[3] = 8'h14;
    pm.v[4] = 8'h3c;
    cgo(MODE_ROBIN, 4'h0);
    repeat (100) @(posedge clk);
    rd(`A_STATUS, 32'h1);
    mexp();
    cread();
    $display("test cell round robin done");
    wr(`A_OV_THR, 32'd100);
    clr(`A_OV_FAULT_A);
    clr(`A_OV_FAULT_B);
    {eo, eu} = '0;
    repeat (100) @(posedge clk);
    mexp();
    cread();
    for (int c = 0; c < 16; c++) pm.v[c] <= 8'h80;
    repeat (100) @(posedge clk);
    cread();
    for (int a = 'h30; a <= 'h3c; a += 4) clr(12'(a));
    {eo, eu} = '0;
    repeat (100) @(posedge clk);
    cread();
    $display("test settings hold and sticky faults done");
    act = 8'($urandom_range(255));
    for (int p = 0; p < 8; p++) pc[p*3 +: 3] = act[p] ? `PIN_ADC_PROTECT : 3'h1;
    ot = 5'($urandom_range(31));
    ut = 3'($urandom_range(7));
    bot = 8'($urandom_range(255));
    tgo(MODE_ROBIN, 3'h0);
    repeat (60) @(posedge clk);
    mexp();
    rd(`A_OT_FAULT, {24'h0, eot});
    rd(`A_UT_FAULT, {24'h0, eut});
    chkp(bps, {8'h0, ep});
    rd(`A_STATUS, 32'h3);
    ref_en <= 1'b0;
    clr(`A_OT_FAULT);
    clr(`A_UT_FAULT);
    repeat (60) @(posedge clk);
    rd(`A_OT_FAULT, 32'hff);
    rd(`A_UT_FAULT, 32'hff);
    ref_en <= 1'b1;
    $display("test temperature round robin done");
    cgo(MODE_SINGLE, 4'h9);
    tgo(MODE_SINGLE, 3'h5);
    repeat (20) @(posedge clk);
    chkp({12'h0, cch}, 16'h9);
    chkp({13'h0, tch}, 16'h5);
    tgo(MODE_BIST, 3'h0);
    clr(`A_OT_FAULT);
    clr(`A_UT_FAULT);
    repeat (60) @(posedge clk);
    chkp({15'h0, tbist}, 16'h1);
    rd(`A_OT_FAULT, 32'h0);
    // Channel 0 would trip the overvoltage check if self-test still detected
    pm.v[0] <= 8'hff;
    cgo(MODE_BIST, 4'h0);
    repeat (80) @(posedge clk);
    chkp({15'h0, cbist}, 16'h1);
    rd(`A_STATUS, 32'hf);
    rd(`A_OV_FAULT_A, 32'h0);
    cgo(MODE_STOP, 4'h0);
    tgo(MODE_STOP, 3'h0);
    repeat (5) @(posedge clk);
    rd(`A_STATUS, 32'h0);
    $display("test modes and stop done");
    close_out();
  end
  initial begin
    #400000;
    n_errors++;
    close_out();
  end
endmodule
